// ### sk_defs.svh
// Constants for the conditional skip unit
`ifndef SK_DEFS_SVH
`define SK_DEFS_SVH

// Instruction codes
`define SK_CODE_PIN0       10'h03A
`define SK_CODE_PIN1       10'h03B
`define SK_CODE_PDWN_DFLT  10'h3F0
`define SK_CODE_T1_DFLT    10'h3F1

// Register byte addresses
`define SK_ADDR_CTRL_A     5'h00
`define SK_ADDR_CTRL_B     5'h04
`define SK_ADDR_CTRL_V     5'h08
`define SK_ADDR_STATE      5'h0C
`define SK_ADDR_IRQ_ST     5'h10
`define SK_ADDR_IRQ_MSK    5'h14

// Field positions
`define SK_POL_BIT         2
`define SK_T1IEN_BIT       2
`define SK_EV_SKIP         0
`define SK_EV_T1SET        1
`define SK_ST_LVL0         0
`define SK_ST_LVL1         1
`define SK_ST_PDWN         2
`define SK_ST_T1F          3
`define SK_ST_PEND         4

// Widths and reset values
`define SK_CTRL_W          4
`define SK_EV_W            2
`define SK_ST_W            5
`define SK_CTRL_RST        4'h0
`define SK_EV_RST          2'h0
`define SK_WORD_RST        32'h0000_0000

`endif

// ### sk_pkg.sv
// Types shared by the conditional skip unit
`default_nettype none
package sk_pkg;

   typedef enum logic [4:0] {
      SK_OP_NONE = 5'b00001,
      SK_OP_PIN0 = 5'b00010,
      SK_OP_PIN1 = 5'b00100,
      SK_OP_PDWN = 5'b01000,
      SK_OP_T1   = 5'b10000
   } sk_op_e;

   typedef enum logic [1:0] {
      SK_BUS_IDLE = 2'b01,
      SK_BUS_ACK  = 2'b10
   } sk_bus_e;

   typedef struct packed {
      logic pin0_skip_polarity;
      logic pin1_skip_polarity;
      logic timer1_irq_enable;
   } sk_cfg_s;

   typedef struct packed {
      logic ext_irq_pin1;
      logic ext_irq_pin0;
   } sk_lvl_s;

endpackage : sk_pkg
`default_nettype wire

// ### sk_sync3.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module sk_sync3 #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_srst,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_async,
   output var  logic [W-1:0] o_level
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;
   logic [W-1:0] lvl_d;

   // Per bit: accept a change once stages two and three agree
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         lvl_q <= '0;
      end else if (i_ce) begin
         s1_q  <= i_async;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign o_level = lvl_q;

endmodule : sk_sync3
`default_nettype wire

// ### sk_skip_unit.sv
// Conditional skip unit: pin, power-down and timer 1 flag tests
`include "sk_defs.svh"
`default_nettype none
module sk_skip_unit
   import sk_pkg::*;
#(
   parameter logic [9:0] P_CODE_PDWN = `SK_CODE_PDWN_DFLT,
   parameter logic [9:0] P_CODE_T1   = `SK_CODE_T1_DFLT
) (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_ce,
   input  wire logic        i_instr_valid,
   input  wire logic [9:0]  i_instr,
   input  wire logic        i_ext_irq_pin0,
   input  wire logic        i_ext_irq_pin1,
   input  wire logic        i_powerdown_flag,
   input  wire logic        i_timer1_set,
   input  wire logic [4:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output var  logic [31:0] o_avs_readdata,
   output var  logic        o_avs_waitrequest,
   output var  logic        o_skip_req,
   output var  logic        o_suppress_exec,
   output var  logic        o_timer1_request_flag,
   output var  logic        o_irq
);

   // Pin levels after synchronisation
   logic [0:0] lvl0;
   logic [0:0] lvl1;
   sk_lvl_s    lvl;

   sk_sync3 #(
      .W (1)
   ) u_sync_pin0 (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_ce    (i_ce),
      .i_async (i_ext_irq_pin0),
      .o_level (lvl0)
   );

   sk_sync3 #(
      .W (1)
   ) u_sync_pin1 (
      .i_clk   (i_clk),
      .i_srst  (i_srst),
      .i_ce    (i_ce),
      .i_async (i_ext_irq_pin1),
      .o_level (lvl1)
   );

   assign lvl.ext_irq_pin0 = lvl0[0];
   assign lvl.ext_irq_pin1 = lvl1[0];

   // Control registers
   logic [`SK_CTRL_W-1:0] ext_irq_ctrl_reg_a_q;
   logic [`SK_CTRL_W-1:0] ext_irq_ctrl_reg_a_d;
   logic [`SK_CTRL_W-1:0] ext_irq_ctrl_reg_b_q;
   logic [`SK_CTRL_W-1:0] ext_irq_ctrl_reg_b_d;
   logic [`SK_CTRL_W-1:0] irq_ctrl_reg_v_q;
   logic [`SK_CTRL_W-1:0] irq_ctrl_reg_v_d;
   logic [`SK_EV_W-1:0]   irq_st_q;
   logic [`SK_EV_W-1:0]   irq_st_d;
   logic [`SK_EV_W-1:0]   irq_msk_q;
   logic [`SK_EV_W-1:0]   irq_msk_d;
   sk_cfg_s               cfg;

   assign cfg.pin0_skip_polarity = ext_irq_ctrl_reg_a_q[`SK_POL_BIT];
   assign cfg.pin1_skip_polarity = ext_irq_ctrl_reg_b_q[`SK_POL_BIT];
   assign cfg.timer1_irq_enable  = irq_ctrl_reg_v_q[`SK_T1IEN_BIT];

   // Execution state
   logic   skip_pend_q;
   logic   skip_pend_d;
   logic   skip_req_q;
   logic   skip_req_d;
   logic   t1f_q;
   logic   t1f_d;
   logic   irq_q;
   logic   irq_d;
   logic   exec_ok;
   logic   skip_now;
   logic   t1_clear;
   sk_op_e op;

   // Bus state
   sk_bus_e     bus_q;
   sk_bus_e     bus_d;
   logic        wait_q;
   logic        wait_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [31:0] rd_mux;
   logic        wr_fire;
   logic [`SK_EV_W-1:0] w1c;

   // Decode; a suppressed instruction is decoded but exec_ok keeps it from executing
   always_comb begin
      op = SK_OP_NONE;
      if (i_instr == `SK_CODE_PIN0) begin
         op = SK_OP_PIN0;
      end else if (i_instr == `SK_CODE_PIN1) begin
         op = SK_OP_PIN1;
      end else if (i_instr == P_CODE_PDWN) begin
         op = SK_OP_PDWN;
      end else if (i_instr == P_CODE_T1) begin
         op = SK_OP_T1;
      end
   end

   assign exec_ok = i_ce & i_instr_valid & ~skip_pend_q;

   // Skip decision, made in the instruction's own cycle
   always_comb begin
      skip_now = 1'b0;
      t1_clear = 1'b0;
      if (exec_ok) begin
         unique case (op)
            SK_OP_PIN0: begin
               skip_now = lvl.ext_irq_pin0 == cfg.pin0_skip_polarity;
            end
            SK_OP_PIN1: begin
               skip_now = lvl.ext_irq_pin1 == cfg.pin1_skip_polarity;
            end
            SK_OP_PDWN: begin
               skip_now = i_powerdown_flag;
            end
            SK_OP_T1: begin
               skip_now = ~cfg.timer1_irq_enable & t1f_q;
               t1_clear = ~cfg.timer1_irq_enable & t1f_q;
            end
            SK_OP_NONE: begin
               skip_now = 1'b0;
            end
         endcase
      end
   end

   // Next values of execution state
   always_comb begin
      skip_pend_d = skip_pend_q;
      skip_req_d  = 1'b0;
      if (i_instr_valid) begin
         skip_pend_d = skip_now;
      end
      skip_req_d = skip_now;
      // Timer set wins over a clear in the same cycle
      t1f_d = (t1f_q & ~t1_clear) | i_timer1_set;
      irq_d = |(irq_st_q & irq_msk_q);
   end

   // Bus reads
   always_comb begin
      rd_mux = `SK_WORD_RST;
      unique case (i_avs_address)
         `SK_ADDR_CTRL_A:  rd_mux[`SK_CTRL_W-1:0] = ext_irq_ctrl_reg_a_q;
         `SK_ADDR_CTRL_B:  rd_mux[`SK_CTRL_W-1:0] = ext_irq_ctrl_reg_b_q;
         `SK_ADDR_CTRL_V:  rd_mux[`SK_CTRL_W-1:0] = irq_ctrl_reg_v_q;
         `SK_ADDR_STATE: begin
            rd_mux[`SK_ST_LVL0] = lvl.ext_irq_pin0;
            rd_mux[`SK_ST_LVL1] = lvl.ext_irq_pin1;
            rd_mux[`SK_ST_PDWN] = i_powerdown_flag;
            rd_mux[`SK_ST_T1F]  = t1f_q;
            rd_mux[`SK_ST_PEND] = skip_pend_q;
         end
         `SK_ADDR_IRQ_ST:  rd_mux[`SK_EV_W-1:0] = irq_st_q;
         `SK_ADDR_IRQ_MSK: rd_mux[`SK_EV_W-1:0] = irq_msk_q;
         default:          rd_mux = `SK_WORD_RST;
      endcase
   end

   // Bus handshake: one wait cycle, write lands at the acknowledge edge
   always_comb begin
      bus_d   = bus_q;
      wait_d  = wait_q;
      rdata_d = rdata_q;
      wr_fire = 1'b0;
      unique case (bus_q)
         SK_BUS_IDLE: begin
            if (i_avs_read | i_avs_write) begin
               bus_d  = SK_BUS_ACK;
               wait_d = 1'b0;
               if (i_avs_read) begin
                  rdata_d = rd_mux;
               end
            end
         end
         SK_BUS_ACK: begin
            bus_d   = SK_BUS_IDLE;
            wait_d  = 1'b1;
            wr_fire = i_avs_write & i_ce;
         end
         default: begin
            bus_d  = SK_BUS_IDLE;
            wait_d = 1'b1;
         end
      endcase
   end

   // Register writes; unmapped writes are dropped
   always_comb begin
      ext_irq_ctrl_reg_a_d = ext_irq_ctrl_reg_a_q;
      ext_irq_ctrl_reg_b_d = ext_irq_ctrl_reg_b_q;
      irq_ctrl_reg_v_d     = irq_ctrl_reg_v_q;
      irq_msk_d            = irq_msk_q;
      w1c                  = `SK_EV_RST;
      if (wr_fire & i_avs_byteenable[0]) begin
         unique case (i_avs_address)
            `SK_ADDR_CTRL_A: begin
               ext_irq_ctrl_reg_a_d = i_avs_writedata[`SK_CTRL_W-1:0];
            end
            `SK_ADDR_CTRL_B: begin
               ext_irq_ctrl_reg_b_d = i_avs_writedata[`SK_CTRL_W-1:0];
            end
            `SK_ADDR_CTRL_V: begin
               irq_ctrl_reg_v_d = i_avs_writedata[`SK_CTRL_W-1:0];
            end
            `SK_ADDR_IRQ_ST: begin
               w1c = i_avs_writedata[`SK_EV_W-1:0];
            end
            `SK_ADDR_IRQ_MSK: begin
               irq_msk_d = i_avs_writedata[`SK_EV_W-1:0];
            end
            default: begin
               w1c = `SK_EV_RST;
            end
         endcase
      end
      // Events win over a clear in the same cycle
      irq_st_d = irq_st_q & ~w1c;
      irq_st_d[`SK_EV_SKIP]  = irq_st_d[`SK_EV_SKIP] | skip_now;
      irq_st_d[`SK_EV_T1SET] = irq_st_d[`SK_EV_T1SET] | i_timer1_set;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         skip_pend_q          <= 1'b0;
         skip_req_q           <= 1'b0;
         t1f_q                <= 1'b0;
         irq_q                <= 1'b0;
         bus_q                <= SK_BUS_IDLE;
         wait_q               <= 1'b1;
         rdata_q              <= `SK_WORD_RST;
         ext_irq_ctrl_reg_a_q <= `SK_CTRL_RST;
         ext_irq_ctrl_reg_b_q <= `SK_CTRL_RST;
         irq_ctrl_reg_v_q     <= `SK_CTRL_RST;
         irq_st_q             <= `SK_EV_RST;
         irq_msk_q            <= `SK_EV_RST;
      end else if (i_ce) begin
         skip_pend_q          <= skip_pend_d;
         skip_req_q           <= skip_req_d;
         t1f_q                <= t1f_d;
         irq_q                <= irq_d;
         bus_q                <= bus_d;
         wait_q               <= wait_d;
         rdata_q              <= rdata_d;
         ext_irq_ctrl_reg_a_q <= ext_irq_ctrl_reg_a_d;
         ext_irq_ctrl_reg_b_q <= ext_irq_ctrl_reg_b_d;
         irq_ctrl_reg_v_q     <= irq_ctrl_reg_v_d;
         irq_st_q             <= irq_st_d;
         irq_msk_q            <= irq_msk_d;
      end
   end

   assign o_skip_req            = skip_req_q;
   assign o_suppress_exec       = skip_pend_q;
   assign o_timer1_request_flag = t1f_q;
   assign o_irq                 = irq_q;
   assign o_avs_readdata        = rdata_q;
   assign o_avs_waitrequest     = wait_q;

   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   logic ex_pin0;
   logic ex_pin1;
   logic ex_pdwn;
   logic ex_t1;
   assign ex_pin0 = exec_ok && (i_instr == `SK_CODE_PIN0);
   assign ex_pin1 = exec_ok && (i_instr == `SK_CODE_PIN1);
   assign ex_pdwn = exec_ok && (i_instr == P_CODE_PDWN);
   assign ex_t1   = exec_ok && (i_instr == P_CODE_T1);

   a_pin0_skip_level: assert property (
      ex_pin0 |=> o_skip_req == ($past(lvl.ext_irq_pin0) == $past(cfg.pin0_skip_polarity)))
      else $error("pin 0 skip does not follow level and polarity");

   a_pin0_one_cycle: assert property (
      ex_pin0 |=> o_suppress_exec == o_skip_req)
      else $error("pin 0 test outcome not ready next cycle");

   a_pin1_skip_level: assert property (
      ex_pin1 |=> o_skip_req == ($past(lvl.ext_irq_pin1) == $past(cfg.pin1_skip_polarity)))
      else $error("pin 1 skip does not follow level and polarity");

   a_pin1_one_cycle: assert property (
      ex_pin1 |=> o_suppress_exec == o_skip_req)
      else $error("pin 1 test outcome not ready next cycle");

   a_pdwn_skip: assert property (
      ex_pdwn |=> o_skip_req == $past(i_powerdown_flag))
      else $error("power-down test skip wrong");

   a_t1_skip_clear: assert property (
      (ex_t1 && !cfg.timer1_irq_enable && t1f_q && !i_timer1_set)
      |=> o_skip_req && !o_timer1_request_flag)
      else $error("timer 1 test failed to skip and clear");

   a_t1_nop_keep: assert property (
      (ex_t1 && cfg.timer1_irq_enable && t1f_q) |=> !o_skip_req && o_timer1_request_flag)
      else $error("timer 1 test acted while enabled");

   a_t1_single_cycle: assert property (
      (ex_t1 && !cfg.timer1_irq_enable && t1f_q) |=> o_suppress_exec ##0 $rose(o_skip_req))
      else $error("timer 1 skip not issued in one cycle");

   a_set_wins_clear: assert property (
      (i_ce && i_timer1_set) |=> o_timer1_request_flag)
      else $error("timer 1 set lost");

   a_suppressed_no_skip: assert property (
      (o_suppress_exec && i_instr_valid && i_ce) |=> !o_suppress_exec && !o_skip_req)
      else $error("suppressed instruction acted");

   a_bus_answers: assert property (
      (i_ce && (i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
      else $error("bus request not acknowledged");

   c_pin0_skip: cover property (ex_pin0 ##1 o_skip_req);
   c_t1_clear: cover property (ex_t1 && t1f_q && !cfg.timer1_irq_enable);
   c_suppress: cover property (o_suppress_exec && i_instr_valid);
   c_bus_write: cover property (wr_fire);

endmodule : sk_skip_unit
`default_nettype wire

// ### tb_conditional_skip_flag_test.sv
// Self-checking bench for the conditional skip unit
`include "sk_defs.svh"
`default_nettype none
module tb_conditional_skip_flag_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        srst;
   logic        ce;
   logic        instr_valid;
   logic [9:0]  instr;
   logic        pin0;
   logic        pin1;
   logic        pdwn;
   logic        t1set;
   logic [4:0]  addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic [3:0]  be;
   logic [31:0] avs_rdata;
   logic        waitreq;
   logic        skip_req;
   logic        suppress;
   logic        t1flag;
   logic        irq;
   logic [31:0] q;
   logic [3:0]  be_sel;
   int          miscompares;
   int          check_count;

   sk_skip_unit u_dut (
      .i_clk                 (clk),
      .i_srst                (srst),
      .i_ce                  (ce),
      .i_instr_valid         (instr_valid),
      .i_instr               (instr),
      .i_ext_irq_pin0        (pin0),
      .i_ext_irq_pin1        (pin1),
      .i_powerdown_flag      (pdwn),
      .i_timer1_set          (t1set),
      .i_avs_address         (addr),
      .i_avs_read            (rd),
      .i_avs_write           (wr),
      .i_avs_writedata       (wdata),
      .i_avs_byteenable      (be),
      .o_avs_readdata        (avs_rdata),
      .o_avs_waitrequest     (waitreq),
      .o_skip_req            (skip_req),
      .o_suppress_exec       (suppress),
      .o_timer1_request_flag (t1flag),
      .o_irq                 (irq)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      rd <= !is_wr;
      wr <= is_wr;
      addr <= a;
      wdata <= d;
      be <= be_sel;
      // Only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      q = avs_rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0000_0000);
      chk(q, exp, what);
   endtask : rd_chk

   task automatic exec(input logic [9:0] code, input logic exp_skip, input string what);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr <= code;
      @(posedge clk);
      instr_valid <= exp_skip;
      #1;
      chk(skip_req, exp_skip, what);
      chk(suppress, exp_skip, "suppress level");
      if (exp_skip) begin
         @(posedge clk);
         instr_valid <= 1'b0;
         #1;
         chk(skip_req, 1'b0, "skipped word decoded");
         chk(suppress, 1'b0, "suppress not cleared");
      end
   endtask : exec

   task automatic t_regs;
      logic [4:0] adr [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h18};
      chk({irq, t1flag, suppress, skip_req, waitreq}, 32'h1, "outputs after reset");
      foreach (adr[i]) rd_chk(adr[i], 32'h0, "reset value");
      bus(1'b1, `SK_ADDR_CTRL_A, 32'hFFFF_FFFF);
      rd_chk(`SK_ADDR_CTRL_A, 32'h0000_000F, "control field width");
      be_sel = 4'hE;
      bus(1'b1, `SK_ADDR_CTRL_A, 32'h0);
      be_sel = 4'hF;
      rd_chk(`SK_ADDR_CTRL_A, 32'h0000_000F, "write without lane 0 kept");
      bus(1'b1, 5'h18, 32'hFFFF_FFFF);
      rd_chk(5'h18, 32'h0, "unmapped read");
      bus(1'b1, `SK_ADDR_CTRL_A, 32'h0);
   endtask : t_regs

   task automatic t_pin(input logic which, input logic pol, input logic lvl);
      bus(1'b1, which ? `SK_ADDR_CTRL_B : `SK_ADDR_CTRL_A, {29'h0, pol, 2'h0});
      @(posedge clk);
      if (which) pin1 <= lvl;
      else pin0 <= lvl;
      repeat (6) @(posedge clk);
      exec(which ? `SK_CODE_PIN1 : `SK_CODE_PIN0, lvl == pol, "pin level test");
   endtask : t_pin

   task automatic t_pdwn;
      @(posedge clk);
      pdwn <= 1'b0;
      exec(`SK_CODE_PDWN_DFLT, 1'b0, "power-down flag clear");
      @(posedge clk);
      pdwn <= 1'b1;
      exec(`SK_CODE_PDWN_DFLT, 1'b1, "power-down flag set");
      rd_chk(`SK_ADDR_STATE, 32'h4 | {30'h0, pin1, pin0}, "power-down flag kept");
      pdwn <= 1'b0;
   endtask : t_pdwn

   task automatic pulse_t1;
      @(posedge clk);
      t1set <= 1'b1;
      @(posedge clk);
      t1set <= 1'b0;
      @(posedge clk);
      #1;
      chk(t1flag, 1'b1, "timer 1 flag set");
   endtask : pulse_t1

   task automatic t_timer1;
      pulse_t1();
      bus(1'b1, `SK_ADDR_CTRL_V, 32'h4);
      exec(`SK_CODE_T1_DFLT, 1'b0, "timer 1 test enabled");
      chk(t1flag, 1'b1, "flag cleared while enabled");
      bus(1'b1, `SK_ADDR_CTRL_V, 32'h0);
      exec(`SK_CODE_T1_DFLT, 1'b1, "timer 1 test flag set");
      chk(t1flag, 1'b0, "flag not cleared");
      exec(`SK_CODE_T1_DFLT, 1'b0, "timer 1 test flag clear");
      // Timer set in the very cycle of the clearing test
      pulse_t1();
      @(posedge clk);
      t1set <= 1'b1;
      instr_valid <= 1'b1;
      instr <= `SK_CODE_T1_DFLT;
      @(posedge clk);
      t1set <= 1'b0;
      #1;
      chk({skip_req, t1flag}, 32'h3, "timer set lost to clear");
      @(posedge clk);
      instr_valid <= 1'b0;
   endtask : t_timer1

   task automatic t_irq;
      bus(1'b1, `SK_ADDR_IRQ_ST, 32'h3);
      rd_chk(`SK_ADDR_IRQ_ST, 32'h0, "status cleared");
      bus(1'b1, `SK_ADDR_IRQ_MSK, 32'h1);
      pdwn <= 1'b1;
      exec(`SK_CODE_PDWN_DFLT, 1'b1, "skip for interrupt");
      @(posedge clk);
      pdwn <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(irq, 1'b1, "irq on skip event");
      bus(1'b1, `SK_ADDR_IRQ_MSK, 32'h0);
      repeat (3) @(posedge clk);
      #1;
      chk(irq, 1'b0, "irq masked");
      bus(1'b1, `SK_ADDR_IRQ_MSK, 32'h1);
      repeat (3) @(posedge clk);
      #1;
      chk(irq, 1'b1, "irq unmasked");
      bus(1'b1, `SK_ADDR_IRQ_ST, 32'h1);
      repeat (3) @(posedge clk);
      #1;
      chk(irq, 1'b0, "irq after clear");
      pulse_t1();
      rd_chk(`SK_ADDR_IRQ_ST, 32'h2, "timer event status");
      chk(irq, 1'b0, "timer event masked");
   endtask : t_irq

   task automatic t_freeze;
      pulse_t1();
      // A clearing test offered while the enable is low must do nothing
      @(posedge clk);
      ce <= 1'b0;
      instr_valid <= 1'b1;
      instr <= `SK_CODE_T1_DFLT;
      repeat (3) @(posedge clk);
      #1;
      chk({suppress, skip_req, t1flag}, 32'h1, "state not frozen");
      @(posedge clk);
      ce <= 1'b1;
      instr_valid <= 1'b0;
      repeat (2) @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk({irq, t1flag, suppress, skip_req, waitreq}, 32'h1, "outputs after mid-run reset");
      rd_chk(`SK_ADDR_CTRL_B, 32'h0, "control after reset");
      rd_chk(`SK_ADDR_IRQ_ST, 32'h0, "status after reset");
   endtask : t_freeze

   initial begin
      #100us;
      miscompares++;
      $display("Error at %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      miscompares = 0;
      check_count = 0;
      srst = 1'b1;
      ce = 1'b1;
      instr_valid = 1'b0;
      instr = 10'h000;
      pin0 = 1'b0;
      pin1 = 1'b0;
      pdwn = 1'b0;
      t1set = 1'b0;
      addr = 5'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      be = 4'h0;
      be_sel = 4'hF;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      t_regs();
      for (int w = 0; w < 2; w++) begin
         for (int k = 0; k < 4; k++) begin
            t_pin(w[0], k[1], k[0]);
         end
      end
      t_pdwn();
      t_timer1();
      t_irq();
      t_freeze();
      report_and_stop();
   end
endmodule : tb_conditional_skip_flag_test
`default_nettype wire
